// ### rtl/ocs_consts.vh
`ifndef OCS_CONSTS_VH
`define OCS_CONSTS_VH
// Register byte offsets
`define OCS_OFF_OUT_CTRL_ONE     12'h000
`define OCS_OFF_OUT_CTRL_THREE   12'h004
`define OCS_OFF_OUT_CTRL_FOUR    12'h008
`define OCS_OFF_FLOAT_A          12'h00C
`define OCS_OFF_FLOAT_B          12'h010
`define OCS_OFF_PLL_CTRL_ONE     12'h014
`define OCS_OFF_PLL_CTRL_TWO     12'h018
`define OCS_OFF_PLL_CTRL_THREE   12'h01C
`define OCS_OFF_PLL_CTRL_NINE    12'h020
`define OCS_OFF_FB_INT_LO        12'h024
`define OCS_OFF_FB_INT_HI        12'h028
`define OCS_OFF_FB_REM           12'h02C
`define OCS_OFF_FB_DEN           12'h030
`define OCS_OFF_FB_BP            12'h034
`define OCS_OFF_SE_DIV           12'h038
`define OCS_OFF_PROG_INC         12'h03C
`define OCS_OFF_STATUS           12'h040
// Output control one fields
`define OCS_F_SRC_SEL            0
`define OCS_F_FREQ_LSB           4
`define OCS_F_FREQ_MSB           7
`define OCS_F_DIFF_FMT           8
// Output control three / four fields
`define OCS_F_EN                 0
`define OCS_F_INV                1
// PLL control one fields
`define OCS_F_PLL_EN             0
`define OCS_F_D1_EN              1
`define OCS_F_MUX_LSB            4
`define OCS_F_MUX_MSB            5
`define OCS_F_HS_LSB             8
`define OCS_F_HS_MSB             11
// Codes and widths
`define OCS_FREQ_PROG            4'hF
`define OCS_BP_RESET             7'h2C
`define OCS_BP_MAX               7'h44
`define OCS_FRAC_TOTAL           68
`define OCS_ACC_W                32
`define OCS_DIV_W                32
`define OCS_SE_DIV_RESET         32'h00000001
`define OCS_HS_RESET             4'h6
// Master clock and synthesis
`define OCS_MASTER_HZ            204800000
`define OCS_STEP_HZ              2000
`define OCS_PROG_MIN_HZ          38880000
`define OCS_PROG_MAX_HZ          77760000
`endif

// ### rtl/ocs_divider.v
`timescale 1ns/10ps
`include "ocs_consts.vh"
// Divide a clock enable stream by a ratio; toggles output on ratio boundary.
module ocs_divider #(
  parameter W = 32
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         tick,
  input  wire [W-1:0] ratio,
  input  wire         run,
  output reg          tickOut,
  output reg          level
);
  reg [W-1:0] countReg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      countReg <= {W{1'b0}};
      tickOut  <= 1'b0;
      level    <= 1'b0;
    end else if (!run) begin
      countReg <= {W{1'b0}};
      tickOut  <= 1'b0;
      level    <= 1'b0;
    end else begin
      tickOut <= 1'b0;
      if (tick) begin
        if (countReg + {{(W-1){1'b0}}, 1'b1} >= ratio) begin
          countReg <= {W{1'b0}};
          tickOut  <= 1'b1;
          level    <= ~level;
        end else begin
          countReg <= countReg + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // ocs_divider

// ### rtl/ocs_output_clock.v
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "ocs_consts.vh"
// Contract
// - Single-ended pin driven only when enabled
// - Single-ended invert complements group clock
// - Float bit puts single-ended pin hi-Z
// - Differential driven when enabled, invert swaps
// - Groups four-seven format from control one
// - Differential disabled: driver off, legs high
// - Synthesis reference from DPLL one or two
// - Phase accumulator adds increment, outputs phase
// - Non-all-ones code selects preset frequency
// - All ones code: programmable 2kHz multiples
// - Multiplying PLL runs only when enabled
// - Input select picks synth or input clock
// - High-speed divider precedes downstream dividers
// - First divider passes only when enabled
// - Feedback ratio integer plus scaled remainder
// - Integer field fixed point, seven integer bits
// - Enable rising edge starts lock reacquisition
// - Single-ended clock is mux clock divided
module ocs_output_clock #(
  parameter GROUP   = 1,
  parameter DIV_W   = `OCS_DIV_W
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [31:0] dpllOneIncrement,
  input  wire [31:0] dpllTwoIncrement,
  input  wire        inputClockTick,
  output reg  [31:0] synthPhaseCode,
  output reg         seClockOut,
  output reg         seClockOe,
  output reg         diffPos,
  output reg         diffNeg,
  output reg         diffDriveOn,
  output reg         diffFormatLvpecl,
  output reg         pllRun,
  output reg         pllRelockPulse,
  output reg  [6:0]  fbIntegerWhole,
  output reg  [67:0] fbFractionScaled
);
  reg  [31:0] outCtrlOneReg;
  reg  [31:0] outCtrlThreeReg;
  reg  [31:0] outCtrlFourReg;
  reg  [31:0] floatAReg;
  reg  [31:0] floatBReg;
  reg  [31:0] pllCtrlOneReg;
  reg  [31:0] pllCtrlTwoReg;
  reg  [31:0] pllCtrlThreeReg;
  reg  [2:0]  pllRangeReg;
  reg  [31:0] fbIntLoReg;
  reg  [31:0] fbIntHiReg;
  reg  [31:0] fbRemReg;
  reg  [31:0] fbDenReg;
  reg  [6:0]  fbBinPointReg;
  reg  [31:0] seDividerReg;
  reg  [31:0] progIncReg;
  reg  [31:0] accReg;
  reg         accMsbReg;
  reg         pllEnPrevReg;
  reg  [31:0] rdNext;
  reg  [31:0] presetInc;
  reg         seLiveEnReg;
  reg         seLiveInvReg;
  reg         diffLiveEnReg;
  reg         diffLiveInvReg;
  reg         inSync1Reg;
  reg         inSync2Reg;
  wire        access    = psel & penable;
  wire        wrStrobe  = access & pwrite;
  wire [3:0]  freqCode  = outCtrlOneReg[`OCS_F_FREQ_MSB:`OCS_F_FREQ_LSB];
  wire [1:0]  pllMux    = pllCtrlOneReg[`OCS_F_MUX_MSB:`OCS_F_MUX_LSB];
  wire        pllEnBit  = pllCtrlOneReg[`OCS_F_PLL_EN];
  wire [31:0] synthRef;
  wire [31:0] synthInc;
  wire [32:0] accSum;
  wire        synthTick;
  wire        pllSrcTick;
  wire        hsTick;
  wire        d1Tick;
  wire        d2Tick;
  wire        muxTick;
  wire        seLevel;
  wire        diffLevel;
  wire        seFloat;
  wire        knownAddr;

  assign knownAddr = (paddr[11:2] <= (`OCS_OFF_STATUS >> 2)) && (paddr[1:0] == 2'b00);

  // Preset table: phase increment per master clock for 15 common rates
  always @* begin
    case (freqCode)
      4'h0:    presetInc = 32'h00A00000;
      4'h1:    presetInc = 32'h01E00000;
      4'h2:    presetInc = 32'h02800000;
      4'h3:    presetInc = 32'h03C00000;
      4'h4:    presetInc = 32'h05000000;
      4'h5:    presetInc = 32'h07800000;
      4'h6:    presetInc = 32'h0A000000;
      4'h7:    presetInc = 32'h0C800000;
      4'h8:    presetInc = 32'h0F000000;
      4'h9:    presetInc = 32'h14000000;
      4'hA:    presetInc = 32'h1E000000;
      4'hB:    presetInc = 32'h28000000;
      4'hC:    presetInc = 32'h30A3D70A;
      4'hD:    presetInc = 32'h3C000000;
      4'hE:    presetInc = 32'h50000000;
      default: presetInc = 32'h00000000;
    endcase
  end

  // Reference from the selected DPLL trims the nominal increment
  assign synthRef = outCtrlOneReg[`OCS_F_SRC_SEL] ? dpllTwoIncrement : dpllOneIncrement;
  assign synthInc = ((freqCode == `OCS_FREQ_PROG) ? progIncReg : presetInc) + synthRef;
  assign accSum   = {1'b0, accReg} + {1'b0, synthInc};
  assign synthTick = accSum[32];

  // Async input clock tick crosses in through two flops
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      inSync1Reg <= 1'b0;
      inSync2Reg <= 1'b0;
    end else begin
      inSync1Reg <= inputClockTick;
      inSync2Reg <= inSync1Reg;
    end
  end

  assign pllSrcTick = (pllMux == 2'b00) ? synthTick : inSync2Reg;

  ocs_divider #(.W(4)) high_speed_divider_ratio (
    .clk     (core_clk),
    .rst     (rst),
    .tick    (pllSrcTick),
    .ratio   (pllCtrlOneReg[`OCS_F_HS_MSB:`OCS_F_HS_LSB]),
    .run     (pllRun),
    .tickOut (hsTick),
    .level   ()
  );

  ocs_divider #(.W(32)) d1Div (
    .clk     (core_clk),
    .rst     (rst),
    .tick    (hsTick),
    .ratio   (pllCtrlTwoReg),
    .run     (pllRun & pllCtrlOneReg[`OCS_F_D1_EN]),
    .tickOut (d1Tick),
    .level   ()
  );

  ocs_divider #(.W(32)) d2Div (
    .clk     (core_clk),
    .rst     (rst),
    .tick    (hsTick),
    .ratio   (pllCtrlThreeReg),
    .run     (pllRun),
    .tickOut (d2Tick),
    .level   (diffLevel)
  );

  // Groups with a multiplying PLL use divider one, others the synth directly
  assign muxTick = (GROUP <= 3) ? d1Tick : synthTick;

  ocs_divider #(.W(DIV_W)) seDiv (
    .clk     (core_clk),
    .rst     (rst),
    .tick    (muxTick),
    .ratio   (seDividerReg[DIV_W-1:0]),
    .run     (1'b1),
    .tickOut (),
    .level   (seLevel)
  );

  assign seFloat = (GROUP <= 4) ? floatAReg[(GROUP-1)%4] : floatBReg[(GROUP-1)%4];

  // APB register file, zero wait states
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      outCtrlOneReg   <= 32'h00000000;
      outCtrlThreeReg <= 32'h00000000;
      outCtrlFourReg  <= 32'h00000000;
      floatAReg       <= 32'h00000000;
      floatBReg       <= 32'h00000000;
      pllCtrlOneReg   <= {20'h00000, `OCS_HS_RESET, 8'h00};
      pllCtrlTwoReg   <= 32'h00000001;
      pllCtrlThreeReg <= 32'h00000001;
      pllRangeReg     <= 3'h0;
      fbIntLoReg      <= 32'h00000000;
      fbIntHiReg      <= 32'h00000000;
      fbRemReg        <= 32'h00000000;
      fbDenReg        <= 32'h00000001;
      fbBinPointReg   <= `OCS_BP_RESET;
      seDividerReg    <= `OCS_SE_DIV_RESET;
      progIncReg      <= 32'h00000000;
      prdata          <= 32'h00000000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~knownAddr;
      prdata  <= rdNext;
      if (wrStrobe && pready) begin
        case (paddr)
          `OCS_OFF_OUT_CTRL_ONE:   outCtrlOneReg   <= pwdata;
          `OCS_OFF_OUT_CTRL_THREE: outCtrlThreeReg <= pwdata;
          `OCS_OFF_OUT_CTRL_FOUR:  outCtrlFourReg  <= pwdata;
          `OCS_OFF_FLOAT_A:        floatAReg       <= pwdata;
          `OCS_OFF_FLOAT_B:        floatBReg       <= pwdata;
          `OCS_OFF_PLL_CTRL_ONE:   pllCtrlOneReg   <= pwdata;
          `OCS_OFF_PLL_CTRL_TWO:   pllCtrlTwoReg   <= pwdata;
          `OCS_OFF_PLL_CTRL_THREE: pllCtrlThreeReg <= pwdata;
          `OCS_OFF_PLL_CTRL_NINE:  pllRangeReg     <= pwdata[2:0];
          `OCS_OFF_FB_INT_LO:      fbIntLoReg      <= pwdata;
          `OCS_OFF_FB_INT_HI:      fbIntHiReg      <= pwdata;
          `OCS_OFF_FB_REM:         fbRemReg        <= pwdata;
          `OCS_OFF_FB_DEN:         fbDenReg        <= pwdata;
          `OCS_OFF_FB_BP:          fbBinPointReg   <= (pwdata[6:0] > `OCS_BP_MAX) ?
                                                      `OCS_BP_MAX : pwdata[6:0];
          `OCS_OFF_SE_DIV:         seDividerReg    <= pwdata;
          `OCS_OFF_PROG_INC:       progIncReg      <= pwdata;
          default:                 ;
        endcase
      end
    end
  end

  always @* begin
    rdNext = 32'h00000000;
    case (paddr)
      `OCS_OFF_OUT_CTRL_ONE:   rdNext = outCtrlOneReg;
      `OCS_OFF_OUT_CTRL_THREE: rdNext = outCtrlThreeReg;
      `OCS_OFF_OUT_CTRL_FOUR:  rdNext = outCtrlFourReg;
      `OCS_OFF_FLOAT_A:        rdNext = floatAReg;
      `OCS_OFF_FLOAT_B:        rdNext = floatBReg;
      `OCS_OFF_PLL_CTRL_ONE:   rdNext = pllCtrlOneReg;
      `OCS_OFF_PLL_CTRL_TWO:   rdNext = pllCtrlTwoReg;
      `OCS_OFF_PLL_CTRL_THREE: rdNext = pllCtrlThreeReg;
      `OCS_OFF_PLL_CTRL_NINE:  rdNext = {29'h00000000, pllRangeReg};
      `OCS_OFF_FB_INT_LO:      rdNext = fbIntLoReg;
      `OCS_OFF_FB_INT_HI:      rdNext = fbIntHiReg;
      `OCS_OFF_FB_REM:         rdNext = fbRemReg;
      `OCS_OFF_FB_DEN:         rdNext = fbDenReg;
      `OCS_OFF_FB_BP:          rdNext = {25'h0000000, fbBinPointReg};
      `OCS_OFF_SE_DIV:         rdNext = seDividerReg;
      `OCS_OFF_PROG_INC:       rdNext = progIncReg;
      `OCS_OFF_STATUS:         rdNext = {24'h000000, seClockOut, diffDriveOn,
                                         pllRun, accMsbReg, freqCode};
      default:                 rdNext = 32'h00000000;
    endcase
  end

  // Synthesis accumulator and PLL enable tracking
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      accReg         <= 32'h00000000;
      accMsbReg      <= 1'b0;
      synthPhaseCode <= 32'h00000000;
      pllRun         <= 1'b0;
      pllEnPrevReg   <= 1'b0;
      pllRelockPulse <= 1'b0;
    end else begin
      accReg         <= accSum[31:0];
      accMsbReg      <= accSum[31];
      synthPhaseCode <= accReg;
      pllEnPrevReg   <= pllEnBit;
      pllRun         <= (GROUP <= 3) ? pllEnBit : 1'b0;
      // Relock only on the 0 to 1 change, so a rewrite of 1 does not disturb lock
      pllRelockPulse <= (GROUP <= 3) & pllEnBit & ~pllEnPrevReg;
    end
  end

  // Feedback ratio: 7 integer bits, the rest fraction per binary point
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fbIntegerWhole   <= 7'h00;
      fbFractionScaled <= 68'h0;
    end else if (pllRelockPulse) begin
      // Latched on relock so a half-written ratio never reaches the loop
      fbIntegerWhole   <= fbIntHiReg[6:0];
      fbFractionScaled <= ({36'h0, fbIntLoReg} << fbBinPointReg) +
                          ((fbDenReg == 32'h00000000) ? 68'h0 :
                           (({36'h0, fbRemReg} << fbBinPointReg) /
                            {36'h0, fbDenReg}));
    end
  end

  // Enable and invert take effect only at the low phase of each clock
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seLiveEnReg    <= 1'b0;
      seLiveInvReg   <= 1'b0;
      diffLiveEnReg  <= 1'b0;
      diffLiveInvReg <= 1'b0;
      seClockOut     <= 1'b0;
      seClockOe      <= 1'b0;
      diffPos        <= 1'b1;
      diffNeg        <= 1'b1;
      diffDriveOn    <= 1'b0;
      diffFormatLvpecl <= 1'b0;
    end else begin
      if (!seLevel) begin
        seLiveEnReg  <= outCtrlThreeReg[`OCS_F_EN];
        seLiveInvReg <= outCtrlThreeReg[`OCS_F_INV];
      end
      if (!diffLevel) begin
        diffLiveEnReg  <= outCtrlFourReg[`OCS_F_EN];
        diffLiveInvReg <= outCtrlFourReg[`OCS_F_INV];
      end
      seClockOut <= seLiveEnReg & (seLevel ^ seLiveInvReg);
      seClockOe  <= seLiveEnReg & ~seFloat;
      diffDriveOn <= diffLiveEnReg;
      diffPos <= diffLiveEnReg ? (diffLevel ^ diffLiveInvReg) : 1'b1;
      diffNeg <= diffLiveEnReg ? ~(diffLevel ^ diffLiveInvReg) : 1'b1;
      diffFormatLvpecl <= (GROUP >= 4) ? outCtrlOneReg[`OCS_F_DIFF_FMT] : 1'b0;
    end
  end
endmodule // ocs_output_clock

// ### test/ocs_output_clock_properties.sv
`timescale 1ns/10ps
module ocs_checker #(
  parameter GROUP = 1
) (
  input logic        core_clk,
  input logic        rst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        seClockOe,
  input logic        diffPos,
  input logic        diffNeg,
  input logic        diffDriveOn,
  input logic        diffFormatLvpecl,
  input logic        pllRun,
  input logic        pllRelockPulse,
  input logic [6:0]  fbIntegerWhole,
  input logic [67:0] fbFractionScaled
);
  // Shadows of the control bits, taken at the edge where a write completes
  logic       seEn_reg, flt_reg, dEn_reg, fmt_reg, pEn_reg;
  logic [6:0] intHi_reg;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {seEn_reg, flt_reg, dEn_reg, fmt_reg, pEn_reg, intHi_reg} <= 12'h000;
    end else if (psel && penable && pready && pwrite) begin
      case (paddr)
        12'h000: fmt_reg <= pwdata[8];
        12'h004: seEn_reg <= pwdata[0];
        12'h008: dEn_reg <= pwdata[0];
        12'h00C: if (GROUP < 5) flt_reg <= pwdata[(GROUP-1)%4];
        12'h010: if (GROUP > 4) flt_reg <= pwdata[(GROUP-1)%4];
        12'h014: pEn_reg <= pwdata[0];
        12'h028: intHi_reg <= pwdata[6:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence setupSeq;
    psel && !penable;
  endsequence
  sequence pulseSeq;
    pllRelockPulse ##1 !pllRelockPulse;
  endsequence
  property fmtP;
    $stable(fmt_reg)[*2] |-> diffFormatLvpecl == (GROUP > 3 && fmt_reg);
  endproperty
  property runP;
    $changed(pllRun) |-> pllRun == (GROUP < 4 && $past(pEn_reg));
  endproperty
  property holdP;
    $changed({fbIntegerWhole, fbFractionScaled}) |-> $past(pllRelockPulse);
  endproperty
  apb_ready_a: assert property (setupSeq |=> pready)
    else $error("ready missing after setup");
  bad_addr_a: assert property (pready && paddr > 12'h040 |-> pslverr)
    else $error("unmapped access not flagged");
  se_enable_a: assert property ($rose(seClockOe) |-> $past(seEn_reg) && !$past(flt_reg))
    else $error("single-ended pin driven while off");
  diff_enable_a: assert property ($rose(diffDriveOn) |-> $past(dEn_reg))
    else $error("differential driver on while off");
  diff_legs_a: assert property (diffDriveOn && $past(diffDriveOn) |-> diffPos != diffNeg)
    else $error("differential legs equal while driven");
  diff_idle_a: assert property ((!diffDriveOn)[*3] |-> diffPos && diffNeg)
    else $error("idle legs not high");
  fmt_select_a: assert property (fmtP)
    else $error("format select wrong");
  pll_run_a: assert property (runP)
    else $error("pll run does not follow enable");
  relock_cause_a: assert property (pllRelockPulse |-> $rose(pllRun))
    else $error("relock without enable rise");
  relock_once_a: assert property ($rose(pllRun) |-> pulseSeq)
    else $error("relock pulse missing or long");
  fb_latch_a: assert property (pllRelockPulse |=> fbIntegerWhole == intHi_reg)
    else $error("feedback integer not latched");
  fb_hold_a: assert property (holdP)
    else $error("feedback changed without relock");
endmodule // ocs_checker
bind ocs_output_clock ocs_checker #(.GROUP(GROUP)) chk (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .seClockOe(seClockOe), .diffPos(diffPos), .diffNeg(diffNeg), .diffDriveOn(diffDriveOn),
  .diffFormatLvpecl(diffFormatLvpecl), .pllRun(pllRun), .pllRelockPulse(pllRelockPulse),
  .fbIntegerWhole(fbIntegerWhole), .fbFractionScaled(fbFractionScaled));

// ### test/ocs_clock_sink.sv
`timescale 1ns/10ps
// Receiving chip: counts clock edges, flags equal differential legs
module ocs_clock_sink (
  input  wire  core_clk,
  input  wire  seClockOut,
  input  wire  seClockOe,
  input  wire  diffPos,
  input  wire  diffNeg,
  input  wire  diffDriveOn,
  output logic inputClockTick,
  output int   edgeCount,
  output int   legFaults
);
  logic seLast, onLast;
  // A floated pin reads as z, so it can never count an edge
  wire  seLine = seClockOe ? seClockOut : 1'bz;
  initial begin
    inputClockTick = 0;
    edgeCount = 0;
    legFaults = 0;
  end
  // Board clock, unrelated in phase to core_clk
  always #7 inputClockTick = ~inputClockTick;
  always @(posedge core_clk) begin
    if (seLine === 1'b1 && seLast === 1'b0) edgeCount <= edgeCount + 1;
    if (diffDriveOn && onLast && diffPos === diffNeg) legFaults <= legFaults + 1;
    seLast <= seLine;
    onLast <= diffDriveOn;
  end
endmodule // ocs_clock_sink

// ### test/test_output_clock_synth_config.sv
`timescale 1ns/10ps
module test_output_clock_synth_config;
  logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, dpllOneIncrement = 0, dpllTwoIncrement = 0, rd, v, d0, d1;
  logic [31:0] prdata, synthPhaseCode;
  logic        pready, pslverr, seClockOut, seClockOe, diffPos, diffNeg, diffDriveOn;
  logic        diffFormatLvpecl, pllRun, pllRelockPulse, inputClockTick;
  logic [6:0]  fbIntegerWhole, ih;
  logic [67:0] fx;
  logic [67:0] fbFractionScaled;
  int          err_total = 0, checked = 0, edgeCount, legFaults, e0;
  logic [31:0] mdl [logic [11:0]];
  logic [11:0] rnd [4] = '{12'h024, 12'h02C, 12'h030, 12'h03C};
  always #2.5 core_clk = ~core_clk;
  ocs_output_clock #(.GROUP(1), .DIV_W(32)) uut (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dpllOneIncrement(dpllOneIncrement), .dpllTwoIncrement(dpllTwoIncrement),
    .inputClockTick(inputClockTick), .synthPhaseCode(synthPhaseCode),
    .seClockOut(seClockOut), .seClockOe(seClockOe), .diffPos(diffPos), .diffNeg(diffNeg),
    .diffDriveOn(diffDriveOn), .diffFormatLvpecl(diffFormatLvpecl), .pllRun(pllRun),
    .pllRelockPulse(pllRelockPulse), .fbIntegerWhole(fbIntegerWhole),
    .fbFractionScaled(fbFractionScaled));
  ocs_clock_sink sink (
    .core_clk(core_clk), .seClockOut(seClockOut), .seClockOe(seClockOe), .diffPos(diffPos),
    .diffNeg(diffNeg), .diffDriveOn(diffDriveOn), .inputClockTick(inputClockTick),
    .edgeCount(edgeCount), .legFaults(legFaults));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      wrap_up;
    end else begin
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask
  // Writable model; the binary point saturates at its top value
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
    if (mdl.exists(a)) mdl[a] = (a == 12'h034 && d > 32'h44) ? 32'h44 : d;
  endtask
  task automatic rdchk(input logic [11:0] a);
    apb(0, a, 0);
    check(rd, mdl.exists(a) ? mdl[a] : 32'h0);
    check({31'h0, er}, {31'h0, !mdl.exists(a)});
  endtask
  task automatic waitv(ref logic s, input logic x);
    int n;
    n = 0;
    while (s !== x && n < 500) begin
      @(posedge core_clk);
      n++;
    end
    check({31'h0, s}, {31'h0, x});
    if (s !== x) wrap_up;
  endtask
  // First edge lets a just-written setting reach the accumulator
  task automatic delta;
    repeat (2) @(posedge core_clk);
    d0 = synthPhaseCode;
    @(posedge core_clk);
    v = synthPhaseCode - d0;
  endtask
  initial begin
    v = $urandom(97565);
    for (int a = 0; a < 64; a += 4) mdl[a[11:0]] = 0;
    {mdl[12'h014], mdl[12'h018], mdl[12'h01C], mdl[12'h030], mdl[12'h034], mdl[12'h038]} =
      {32'h600, 32'h1, 32'h1, 32'h1, 32'h2C, 32'h1};
    repeat (20) @(posedge core_clk);
    rst <= 0;
    check({diffPos, diffNeg, diffDriveOn, seClockOe, pllRun}, 5'b11000);
    foreach (mdl[a]) rdchk(a);
    wr(12'h100, 32'hA5);
    rdchk(12'h100);
    wr(12'h034, 32'h50);
    rdchk(12'h034);
    wr(12'h034, 32'h2C);
    foreach (rnd[i]) begin
      wr(rnd[i], $urandom);
      rdchk(rnd[i]);
    end
    wr(12'h030, 32'h0000EC13);
    rdchk(12'h030);
    $display("register test done");
    for (int c = 0; c < 16; c++) begin
      wr(12'h000, {24'h0, c[3:0], 4'h0});
      apb(0, 12'h040, 0);
      check(rd[3:0], c[3:0]);
    end
    delta;
    check(v, mdl[12'h03C]);
    wr(12'h000, 32'h100);
    v = $urandom;
    dpllOneIncrement <= v;
    dpllTwoIncrement <= v + 1;
    delta;
    d1 = v;
    wr(12'h001, 32'h101);
    rdchk(12'h001);
    wr(12'h000, 32'h101);
    delta;
    check(v - d1, 32'h1);
    $display("synthesis test done");
    dpllOneIncrement <= 0;
    dpllTwoIncrement <= 0;
    wr(12'h03C, 32'h40000000);
    wr(12'h000, 32'h1F0);
    wr(12'h014, 32'h603);
    wr(12'h004, 1);
    waitv(seClockOe, 1);
    e0 = edgeCount;
    repeat (200) @(posedge core_clk);
    check({31'h0, edgeCount > e0}, 1);
    // Synthesis stopped: only the input clock path can still make edges
    wr(12'h03C, 0);
    wr(12'h014, 32'h613);
    e0 = edgeCount;
    repeat (200) @(posedge core_clk);
    check({31'h0, edgeCount > e0}, 1);
    wr(12'h014, 32'h603);
    wr(12'h03C, 32'h40000000);
    wr(12'h00C, 1);
    waitv(seClockOe, 0);
    wr(12'h00C, 0);
    waitv(seClockOe, 1);
    wr(12'h004, 0);
    waitv(seClockOe, 0);
    wr(12'h008, 1);
    waitv(diffDriveOn, 1);
    wr(12'h008, 3);
    repeat (50) @(posedge core_clk);
    check(legFaults, 0);
    wr(12'h008, 0);
    waitv(diffDriveOn, 0);
    $display("output test done");
    wr(12'h020, 32'h3);
    rdchk(12'h020);
    for (int i = 0; i < 2; i++) begin
      v = $urandom;
      ih = 7'h30 + {5'h00, v[1:0]};
      fx = ({36'h0, v} << 44) + ((68'h1 << 44) / 68'h2);
      wr(12'h024, v);
      wr(12'h02C, 32'h1);
      wr(12'h030, 32'h2);
      wr(12'h028, {25'h0, ih});
      wr(12'h014, 32'h600);
      wr(12'h014, 32'h603);
      waitv(pllRelockPulse, 1);
      @(posedge core_clk);
      check(fbIntegerWhole, ih);
      check({31'h0, fbFractionScaled === fx}, 32'h1);
      check(pllRun, 1);
    end
    wr(12'h014, 32'h600);
    waitv(pllRun, 0);
    $display("pll test done");
    wrap_up;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    err_total++;
    wrap_up;
  end
endmodule // test_output_clock_synth_config
